// ---- shared/sfbm_pkg.sv ----
// shared types, constants and lane helpers for the fifo flag, mailbox and bus matching block
package sfbm_pkg;

    // ************************************************************
    // widths, lanes and reset values
    // ************************************************************
    localparam int DATA_W = 36;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam logic [35:0] MASK_LONG = 36'hFFFFFFFFF;
    localparam logic [35:0] MASK_WORD = 36'h00003FFFF;
    localparam logic [35:0] MASK_BYTE = 36'h0000001FF;
    localparam logic [35:0] DATA_RST = 36'h000000000;
    localparam logic [1:0] LANE_FIRST = 2'h0;
    localparam logic [1:0] LANE_LAST_WORD = 2'h1;
    localparam logic [1:0] LANE_LAST_BYTE = 2'h3;
    localparam logic [1:0] LANE_STEP = 2'h1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {BUS_LONG, BUS_WORD, BUS_BYTE} sfbmBus_e;

    typedef struct packed {
        logic clk;
        logic chipSelN;
        logic direction;
        logic xferQual;
        logic mailPick;
        logic [DATA_W-1:0] data;
    } sfbmPortPins_s;

    typedef struct packed {
        sfbmBus_e busSize;
        logic bigEndian;
    } sfbmCfg_s;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [DATA_W-1:0] laneMask(input sfbmBus_e busSize);
        unique case (busSize)
            BUS_LONG: laneMask = MASK_LONG;
            BUS_WORD: laneMask = MASK_WORD;
            BUS_BYTE: laneMask = MASK_BYTE;
            default: laneMask = MASK_LONG;
        endcase
    endfunction : laneMask

    function automatic logic [1:0] lastLane(input sfbmBus_e busSize);
        unique case (busSize)
            BUS_LONG: lastLane = LANE_FIRST;
            BUS_WORD: lastLane = LANE_LAST_WORD;
            BUS_BYTE: lastLane = LANE_LAST_BYTE;
            default: lastLane = LANE_FIRST;
        endcase
    endfunction : lastLane

    function automatic logic [DATA_W-1:0] pickLane(input logic [DATA_W-1:0] word, input sfbmBus_e busSize,
                                                   input logic bigEndian, input logic [1:0] idx);
        logic [1:0] slot;
        slot = bigEndian ? (LANE_LAST_BYTE - idx) : idx;
        pickLane = word;
        unique case (busSize)
            BUS_LONG: pickLane = word;
            BUS_WORD: pickLane = {{(DATA_W-WORD_W){1'b0}}, (bigEndian ^ idx[0]) ? word[35:18] : word[17:0]};
            BUS_BYTE: pickLane = {{(DATA_W-BYTE_W){1'b0}}, word[BYTE_W*slot +: BYTE_W]};
            default: pickLane = word;
        endcase
    endfunction : pickLane

endpackage : sfbm_pkg

// ---- tb/sfbm_port_clocks.sv ----
// free-running port clocks of the far-side processors
module sfbm_port_clocks (
    input wire logic core_clk,
    output logic portAClock,
    output logic portBClock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] phase_r = 4'h0;
    // ****
    // ten-cycle period, b lags a
    // ****
    always_ff @(posedge core_clk) begin
        phase_r <= (phase_r == 4'h9) ? 4'h0 : phase_r + 4'h1;
    end
    assign portAClock = phase_r < 4'h5;
    assign portBClock = phase_r >= 4'h2 && phase_r < 4'h7;
endmodule : sfbm_port_clocks

// ---- tb/test_sfbm_fifo_top.sv ----
// self-checking bench for the fifo flag, mailbox and bus matching block
module test_sfbm_fifo_top
    import sfbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [35:0] din; logic [35:0] dout;} sfbmRow_s;
    localparam sfbmRow_s ROWS [2] = '{'{36'hFFFFFFFFF, 36'hFFFFFFFFF}, '{36'h0A5A5A5A5, 36'h0A5A5A5A5}};
    localparam sfbmPortPins_s IDLE = {5'h08, 36'hFFFFFFFFF};
    localparam logic [35:0] WRD = 36'h123456789;
    logic core_clk, rst_b, mrN, aClk, bClk, rpN, ft, bm, bs, be, spc, avl, drnN, filN, abN, baN, aOe, bOe;
    logic [DATA_W-1:0] aOut, bOut, seenA, seenB;
    sfbmPortPins_s pa, pb;
    int failures, n_compared;
    sfbm_port_clocks sfbm_port_clocks_i (.core_clk(core_clk), .portAClock(aClk), .portBClock(bClk));
    sfbm_fifo_top sfbm_fifo_top_i (
        .core_clk(core_clk), .rst_b(rst_b), .masterResetN(mrN), .portAClock(aClk),
        .portAChipSelN(pa.chipSelN), .portADirection(pa.direction), .portAXferQualifier(pa.xferQual),
        .portAMailPick(pa.mailPick), .portADataIn(pa.data), .portADataOut(aOut), .portADataOe(aOe),
        .portBClock(bClk), .portBChipSelN(pb.chipSelN), .portBDirection(pb.direction),
        .portBXferQualifier(pb.xferQual), .portBMailPick(pb.mailPick), .portBDataIn(pb.data),
        .portBDataOut(bOut), .portBDataOe(bOe), .busMatchSelect(bm), .busSizeSelect(bs),
        .byteOrderSelect(be), .fallThroughMode(ft), .replayPulseN(rpN), .nearDrainedOffset(10'h001),
        .nearFilledOffset(10'h003), .spaceAvailFlag(spc), .dataAvailFlag(avl), .nearDrainedFlagN(drnN),
        .nearFilledFlagN(filN), .mailAbPendingN(abN), .mailBaPendingN(baN)
    );
    // ****
    // tasks
    // ****
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic flg(input logic seen, input logic exp);
        chk({35'h0, seen}, {35'h0, exp});
    endtask : flg
    task automatic pause();
        repeat (30) @(posedge core_clk);
    endtask : pause
    task automatic acc(input bit onB, input logic dir, input logic pick, input logic [35:0] d);
        sfbmPortPins_s p;
        p = {2'h0, dir, 1'b1, pick, d};
        @(posedge core_clk);
        if (onB) pb <= p;
        else pa <= p;
        if (onB) @(posedge bClk);
        else @(posedge aClk);
        repeat (8) @(posedge core_clk);
        seenA = aOut;
        seenB = bOut;
        flg(onB ? bOe : aOe, onB ? dir : ~dir);
        if (onB) pb <= {IDLE[40:36], ~d};
        else pa <= {IDLE[40:36], ~d};
    endtask : acc
    task automatic mreset(input logic m, input logic s, input logic e);
        @(posedge core_clk);
        {bm, bs, be} <= {m, s, e};
        mrN <= 1'b0;
        repeat (5) @(posedge core_clk);
        mrN <= 1'b1;
        pause();
        flg(spc, 1'b1);
        flg(avl, 1'b0);
    endtask : mreset
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ****
    // clock, watchdog, sequence
    // ****
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        print_verdict();
    end
    initial begin
        {rst_b, mrN, rpN, ft, bm, bs, be} = 7'h10;
        pa = IDLE;
        pb = IDLE;
        failures = 0;
        n_compared = 0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        mreset(1'b0, 1'b0, 1'b0);
        foreach (ROWS[i]) begin
            acc(1'b0, 1'b1, 1'b1, ROWS[i].din);
            acc(1'b0, 1'b1, 1'b1, ~ROWS[i].din);
            pause();
            flg(abN, 1'b0);
            acc(1'b1, 1'b1, 1'b1, 36'h0);
            chk(seenB, ROWS[i].dout);
            pause();
            flg(abN, 1'b1);
            acc(1'b1, 1'b0, 1'b1, ROWS[i].din);
            pause();
            flg(baN, 1'b0);
            acc(1'b0, 1'b0, 1'b1, 36'h0);
            chk(seenA, ROWS[i].dout);
            pause();
            flg(baN, 1'b1);
        end
        for (int i = 0; i < 1024; i++) begin
            acc(1'b0, 1'b1, 1'b0, 36'(i));
            if (i < 2) begin
                pause();
                flg(drnN, i[0]);
            end
        end
        acc(1'b0, 1'b1, 1'b0, 36'hFFFFFFFFF);
        pause();
        flg(spc, 1'b0);
        flg(filN, 1'b0);
        flg(avl, 1'b1);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 1'b1, 1'b0, 36'h0);
            chk(seenB, 36'(k));
        end
        pause();
        flg(spc, 1'b1);
        flg(filN, 1'b1);
        @(posedge core_clk);
        ft <= 1'b1;
        rpN <= 1'b0;
        repeat (6) @(posedge core_clk);
        rpN <= 1'b1;
        pause();
        flg(spc, 1'b1);
        acc(1'b1, 1'b1, 1'b0, 36'h0);
        chk(seenB, 36'h4);
        ft <= 1'b0;
        pause();
        @(posedge core_clk);
        rpN <= 1'b0;
        repeat (6) @(posedge core_clk);
        rpN <= 1'b1;
        pause();
        flg(spc, 1'b0);
        acc(1'b1, 1'b1, 1'b0, 36'h0);
        chk(seenB, 36'h0);
        mreset(1'b1, 1'b0, 1'b1);
        acc(1'b0, 1'b1, 1'b0, WRD);
        acc(1'b0, 1'b1, 1'b1, 36'hFFFFFFFFF);
        pause();
        acc(1'b1, 1'b1, 1'b0, 36'h0);
        chk(seenB, WRD >> WORD_W);
        acc(1'b1, 1'b1, 1'b0, 36'h0);
        chk(seenB, WRD & MASK_WORD);
        acc(1'b1, 1'b1, 1'b1, 36'h0);
        chk(seenB, MASK_WORD);
        print_verdict();
    end
endmodule : test_sfbm_fifo_top

// ---- verilog/sfbm_fifo_top.sv ----
// fifo flags, mailboxes, port b bus matching and retransmit
module sfbm_fifo_top
    import sfbm_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic masterResetN,
    input wire logic portAClock,
    input wire logic portAChipSelN,
    input wire logic portADirection,
    input wire logic portAXferQualifier,
    input wire logic portAMailPick,
    input wire logic [DATA_W-1:0] portADataIn,
    output logic [DATA_W-1:0] portADataOut,
    output logic portADataOe,
    input wire logic portBClock,
    input wire logic portBChipSelN,
    input wire logic portBDirection,
    input wire logic portBXferQualifier,
    input wire logic portBMailPick,
    input wire logic [DATA_W-1:0] portBDataIn,
    output logic [DATA_W-1:0] portBDataOut,
    output logic portBDataOe,
    input wire logic busMatchSelect,
    input wire logic busSizeSelect,
    input wire logic byteOrderSelect,
    input wire logic fallThroughMode,
    input wire logic replayPulseN,
    input wire logic [AW-1:0] nearDrainedOffset,
    input wire logic [AW-1:0] nearFilledOffset,
    output logic spaceAvailFlag,
    output logic dataAvailFlag,
    output logic nearDrainedFlagN,
    output logic nearFilledFlagN,
    output logic mailAbPendingN,
    output logic mailBaPendingN
);
    localparam int PW = AW + 1;
    localparam int MISC_W = 6 + 2 * AW;
    localparam logic [PW-1:0] DEPTH_CNT = PW'(DEPTH);
    localparam logic [PW-1:0] PTR_ZERO = '0;
    localparam logic [PW-1:0] PTR_STEP = PW'(1);

    if (!(DEPTH == 1024 || DEPTH == 4096 || DEPTH == 16384) || AW != $clog2(DEPTH)) begin : gBadDepth
        $error("depth must be 1024, 4096 or 16384");
    end

    // ************************************************************
    // reset release and pin synchronisers
    // ************************************************************
    logic rstMeta, rstSyncN;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    sfbmPortPins_s pinA, pinB, pinAS, pinBS;
    logic [MISC_W-1:0] miscIn, miscS;
    assign pinA = {portAClock, portAChipSelN, portADirection, portAXferQualifier, portAMailPick, portADataIn};
    assign pinB = {portBClock, portBChipSelN, portBDirection, portBXferQualifier, portBMailPick, portBDataIn};
    assign miscIn = {masterResetN, busMatchSelect, busSizeSelect, byteOrderSelect, fallThroughMode,
                     replayPulseN, nearDrainedOffset, nearFilledOffset};

    sfbm_sync #(.WIDTH($bits(sfbmPortPins_s))) uSyncA (.core_clk(core_clk), .rstSyncN(rstSyncN), .din(pinA),
                                                       .dout(pinAS));
    sfbm_sync #(.WIDTH($bits(sfbmPortPins_s))) uSyncB (.core_clk(core_clk), .rstSyncN(rstSyncN), .din(pinB),
                                                       .dout(pinBS));
    sfbm_sync #(.WIDTH(MISC_W)) uSyncMisc (.core_clk(core_clk), .rstSyncN(rstSyncN), .din(miscIn), .dout(miscS));

    logic mrS, bmS, sizeS, beS, fallS, replayS;
    logic [AW-1:0] offX, offY;
    assign {mrS, bmS, sizeS, beS, fallS, replayS, offX, offY} = miscS;

    // ************************************************************
    // port clock edges and access decode
    // ************************************************************
    logic aClkPrev_r, bClkPrev_r, mrPrev_r;
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            aClkPrev_r <= 1'b0;
            bClkPrev_r <= 1'b0;
            mrPrev_r <= 1'b0;
        end else begin
            aClkPrev_r <= pinAS.clk;
            bClkPrev_r <= pinBS.clk;
            mrPrev_r <= mrS;
        end
    end

    logic aRise, bRise, inReset, mrRise;
    logic aSel, bSel, fifoWrReq, mail1WrReq, mail2RdReq, fifoRdReq, mail1RdReq, mail2WrReq;
    assign aRise = pinAS.clk & ~aClkPrev_r;
    assign bRise = pinBS.clk & ~bClkPrev_r;
    assign inReset = ~mrS;
    assign mrRise = mrS & ~mrPrev_r;
    assign aSel = aRise & ~pinAS.chipSelN & pinAS.xferQual & ~inReset;
    assign bSel = bRise & ~pinBS.chipSelN & pinBS.xferQual & ~inReset;
    assign fifoWrReq = aSel & pinAS.direction & ~pinAS.mailPick;
    assign mail1WrReq = aSel & pinAS.direction & pinAS.mailPick;
    assign mail2RdReq = aSel & ~pinAS.direction & pinAS.mailPick;
    assign fifoRdReq = bSel & pinBS.direction & ~pinBS.mailPick;
    assign mail1RdReq = bSel & pinBS.direction & pinBS.mailPick;
    assign mail2WrReq = bSel & ~pinBS.direction & pinBS.mailPick;

    // ************************************************************
    // configuration caught at master reset release
    // ************************************************************
    sfbmCfg_s cfg_r;
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cfg_r <= '{busSize: BUS_LONG, bigEndian: 1'b0};
        end else if (mrRise) begin
            cfg_r.busSize <= !bmS ? BUS_LONG : (sizeS ? BUS_BYTE : BUS_WORD);
            cfg_r.bigEndian <= beS;
        end
    end

    // ************************************************************
    // pointers, lanes and storage
    // ************************************************************
    logic [PW-1:0] wrPtr_r, rdPtr_r, rdPtrA1_r, wrPtrB1_r;
    logic [1:0] laneIdx_r;
    logic spaceAvail_r, dataAvail_r, nearDrainedN_r, nearFilledN_r;
    logic wrDo, needNew, rdDo, rdWord, replayDo, loadPend_r;
    logic [DATA_W-1:0] ramRdData, fifoWord_r, fifoOut_r;

    assign wrDo = fifoWrReq & spaceAvail_r;
    assign needNew = (laneIdx_r == LANE_FIRST);
    assign replayDo = ~replayS & ~fallS & ~inReset;
    assign rdDo = fifoRdReq & ~replayDo & (needNew ? dataAvail_r : 1'b1);
    assign rdWord = rdDo & needNew;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrPtr_r <= PTR_ZERO;
        end else if (inReset) begin
            wrPtr_r <= PTR_ZERO;
        end else if (wrDo) begin
            wrPtr_r <= wrPtr_r + PTR_STEP;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdPtr_r <= PTR_ZERO;
            laneIdx_r <= LANE_FIRST;
        end else if (inReset || replayDo) begin
            rdPtr_r <= PTR_ZERO;
            laneIdx_r <= LANE_FIRST;
        end else if (rdDo) begin
            rdPtr_r <= rdWord ? rdPtr_r + PTR_STEP : rdPtr_r;
            laneIdx_r <= (laneIdx_r == lastLane(cfg_r.busSize)) ? LANE_FIRST : laneIdx_r + LANE_STEP;
        end
    end

    sfbm_ram #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) uRam (
        .core_clk(core_clk),
        .wrEn(wrDo),
        .wrAddr(wrPtr_r[AW-1:0]),
        .wrData(pinAS.data),
        .rdEn(rdWord),
        .rdAddr(rdPtr_r[AW-1:0]),
        .rdData(ramRdData)
    );

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            loadPend_r <= 1'b0;
            fifoWord_r <= DATA_RST;
            fifoOut_r <= DATA_RST;
        end else begin
            loadPend_r <= rdWord;
            if (loadPend_r) begin
                fifoWord_r <= ramRdData;
                fifoOut_r <= pickLane(ramRdData, cfg_r.busSize, cfg_r.bigEndian, LANE_FIRST);
            end else if (rdDo && !needNew) begin
                fifoOut_r <= pickLane(fifoWord_r, cfg_r.busSize, cfg_r.bigEndian, laneIdx_r);
            end
        end
    end

    // ************************************************************
    // flags on the write side (port a edges)
    // ************************************************************
    logic [PW-1:0] levelA, levelB, rdNext, fillThresh;
    assign levelA = (wrDo ? wrPtr_r + PTR_STEP : wrPtr_r) - rdPtrA1_r;
    assign fillThresh = DEPTH_CNT - {1'b0, offY};
    assign rdNext = replayDo ? PTR_ZERO : (rdWord ? rdPtr_r + PTR_STEP : rdPtr_r);
    assign levelB = wrPtrB1_r - rdNext;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdPtrA1_r <= PTR_ZERO;
            spaceAvail_r <= 1'b0;
            nearFilledN_r <= 1'b1;
        end else if (inReset) begin
            rdPtrA1_r <= PTR_ZERO;
            spaceAvail_r <= 1'b0;
            nearFilledN_r <= 1'b1;
        end else if (aRise) begin
            rdPtrA1_r <= rdPtr_r;
            spaceAvail_r <= (levelA != DEPTH_CNT);
            nearFilledN_r <= (levelA < fillThresh);
        end
    end

    // ************************************************************
    // flags on the read side (port b edges)
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrPtrB1_r <= PTR_ZERO;
            dataAvail_r <= 1'b0;
            nearDrainedN_r <= 1'b0;
        end else if (inReset) begin
            wrPtrB1_r <= PTR_ZERO;
            dataAvail_r <= 1'b0;
            nearDrainedN_r <= 1'b0;
        end else if (bRise) begin
            wrPtrB1_r <= wrPtr_r;
            dataAvail_r <= (levelB != PTR_ZERO);
            nearDrainedN_r <= (levelB > {1'b0, offX});
        end
    end

    // ************************************************************
    // mailboxes
    // ************************************************************
    logic [DATA_W-1:0] mail1_r, mail2_r;
    logic mailAb_r, mailBa_r;
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mail1_r <= DATA_RST;
            mailAb_r <= 1'b1;
        end else if (inReset) begin
            mailAb_r <= 1'b1;
        end else if (mail1WrReq && mailAb_r) begin
            mail1_r <= pinAS.data & laneMask(cfg_r.busSize);
            mailAb_r <= 1'b0;
        end else if (mail1RdReq) begin
            mailAb_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mail2_r <= DATA_RST;
            mailBa_r <= 1'b1;
        end else if (inReset) begin
            mailBa_r <= 1'b1;
        end else if (mail2WrReq && mailBa_r) begin
            mail2_r <= pinBS.data & laneMask(cfg_r.busSize);
            mailBa_r <= 1'b0;
        end else if (mail2RdReq) begin
            mailBa_r <= 1'b1;
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            portADataOut <= DATA_RST;
            portADataOe <= 1'b0;
            portBDataOut <= DATA_RST;
            portBDataOe <= 1'b0;
        end else begin
            portADataOut <= mail2_r;
            portADataOe <= ~pinAS.chipSelN & ~pinAS.direction;
            portBDataOut <= pinBS.mailPick ? mail1_r : fifoOut_r;
            portBDataOe <= ~pinBS.chipSelN & pinBS.direction;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            spaceAvailFlag <= 1'b0;
            dataAvailFlag <= 1'b0;
            nearDrainedFlagN <= 1'b0;
            nearFilledFlagN <= 1'b1;
            mailAbPendingN <= 1'b1;
            mailBaPendingN <= 1'b1;
        end else begin
            spaceAvailFlag <= spaceAvail_r;
            dataAvailFlag <= dataAvail_r;
            nearDrainedFlagN <= nearDrainedN_r;
            nearFilledFlagN <= nearFilledN_r;
            mailAbPendingN <= mailAb_r;
            mailBaPendingN <= mailBa_r;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_fullBlocks;
        @(posedge core_clk) disable iff (!rstSyncN)
        (fifoWrReq && !spaceAvail_r && !inReset) |=> (wrPtr_r == $past(wrPtr_r));
    endproperty
    a_fullBlocks: assert property (p_fullBlocks) else $error("write taken while no space");

    property p_spaceRise;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(spaceAvail_r) |-> ($past(aRise) && $past(levelA) != DEPTH_CNT);
    endproperty
    a_spaceRise: assert property (p_spaceRise) else $error("space flag rose off a write edge");

    property p_wrStep;
        @(posedge core_clk) disable iff (!rstSyncN)
        (wrDo && !inReset) |=> (wrPtr_r == $past(wrPtr_r) + PTR_STEP) ##1 $stable(wrPtr_r) [*1];
    endproperty
    a_wrStep: assert property (p_wrStep) else $error("write pointer step wrong");

    property p_nearDrained;
        @(posedge core_clk) disable iff (!rstSyncN)
        (bRise && !inReset) |=> (nearDrainedN_r == ($past(levelB) > {1'b0, $past(offX)}));
    endproperty
    a_nearDrained: assert property (p_nearDrained) else $error("near drained flag wrong");

    property p_nearFilled;
        @(posedge core_clk) disable iff (!rstSyncN)
        (aRise && !inReset) |=> (nearFilledN_r == ($past(levelA) < $past(fillThresh)));
    endproperty
    a_nearFilled: assert property (p_nearFilled) else $error("near filled flag wrong");

    property p_mailHold;
        @(posedge core_clk) disable iff (!rstSyncN)
        (mail1WrReq && !mailAb_r) |=> $stable(mail1_r);
    endproperty
    a_mailHold: assert property (p_mailHold) else $error("mail written while pending");

    property p_mail1Read;
        @(posedge core_clk) disable iff (!rstSyncN)
        (mail1RdReq && !(mail1WrReq && mailAb_r)) |=> ##1 mailAbPendingN;
    endproperty
    a_mail1Read: assert property (p_mail1Read) else $error("first mail flag not set by read");

    property p_mail2Read;
        @(posedge core_clk) disable iff (!rstSyncN)
        (mail2RdReq && !(mail2WrReq && mailBa_r)) |=> ##1 mailBaPendingN;
    endproperty
    a_mail2Read: assert property (p_mail2Read) else $error("second mail flag not set by read");

    property p_bSource;
        @(posedge core_clk) disable iff (!rstSyncN)
        pinBS.mailPick |=> (portBDataOut == $past(mail1_r));
    endproperty
    a_bSource: assert property (p_bSource) else $error("port b not showing mail");

    property p_replay;
        @(posedge core_clk) disable iff (!rstSyncN)
        replayDo |=> (rdPtr_r == PTR_ZERO && laneIdx_r == LANE_FIRST);
    endproperty
    a_replay: assert property (p_replay) else $error("replay did not rewind read pointer");

    property p_replayIgnored;
        @(posedge core_clk) disable iff (!rstSyncN)
        (!replayS && fallS && !rdDo && !inReset) |=> $stable(rdPtr_r);
    endproperty
    a_replayIgnored: assert property (p_replayIgnored) else $error("replay acted in fall through");

endmodule : sfbm_fifo_top

// ---- verilog/sfbm_ram.sv ----
// fifo storage array with registered read data
module sfbm_ram #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic core_clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : sfbm_ram

// ---- verilog/sfbm_sync.sv ----
// two flip-flop synchroniser for pin inputs
module sfbm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rstSyncN,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sfbm_sync
